// ==== cfs_regs.sv ====
// Pulse-output scaling and operating-mode registers behind the serial port
//
// Summary of operation
// - Active pulse numerator value feeds the active pulse scaling numerator.
// - Active numerator bits 15..13 show reverse active power for phases A, B, C.
// - Twelve-bit active denominator, reset 0x3f, feeds active pulse scaling denominator.
// - Reactive pulse numerator value feeds the reactive pulse scaling numerator.
// - Reactive numerator bits 15..13 show reverse reactive power for phases A, B, C.
// - Twelve-bit reactive denominator, reset 0x3f, feeds reactive pulse scaling denominator.
// - Read-only count of one bits in the register last read; reads of the count register itself leave it unchanged.
// - Mode bit 0 set bypasses current-channel high-pass filters.
// - Mode bit 1 set bypasses low-pass filters after the power multipliers.
// - Mode bit 2, set at reset, turns both pulse outputs off.
// - Shutdown code 100 swaps voltage and current input paths.
// - Shutdown code 001 powers down only the current-channel converters.
// - Code 011 sleeps, 111 powers down, 010 turns off voltage converters.
`timescale 1ns/1ps

module cfs_regs
    import cfs_pkg::*;
#(
    parameter int          QUIET_CYCLES = cfs_pkg::CFS_QUIET_CYCLES,
    parameter logic [7:0]  DIE_VERSION  = 8'h5a  // Arbitrary value
)
(
    input  wire  logic        ref_clk,
    input  wire  logic        rst_b,
    // Serial port
    input  wire  logic        sclk,
    input  wire  logic        cs_b,
    input  wire  logic        din,
    output logic              dout,
    output logic              dout_oe,
    // Datapath status
    input  wire  logic [2:0]  active_reverse,
    input  wire  logic [2:0]  reactive_reverse,
    input  wire  logic        active_pulse_raw,
    input  wire  logic        reactive_pulse_raw,
    // Scaling values
    output logic [12:0]       active_scale_num,
    output logic [11:0]       active_scale_den,
    output logic [12:0]       reactive_scale_num,
    output logic [11:0]       reactive_scale_den,
    // Pulse outputs
    output logic              active_pulse_out,
    output logic              reactive_pulse_out,
    // Mode controls
    output logic              highpass_bypass,
    output logic              lowpass_bypass,
    output logic              pulse_outputs_off,
    output logic              input_swap,
    output logic              current_adc_off,
    output logic              voltage_adc_off,
    output logic              current_to_voltage,
    output logic              voltage_to_current,
    output logic              sleep_mode,
    output logic              power_down,
    output logic              soft_reset_busy
);
    import cfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State declarations

    typedef enum logic [1:0]
    {
        CFS_ST_CMD  = 2'b00,
        CFS_ST_DATA = 2'b01,
        CFS_ST_DONE = 2'b10
    } cfs_state_e;

    cfs_state_e   st_q,       st_d;
    logic         sclk_q,     sclk_d;
    logic [5:0]   bit_cnt_q,  bit_cnt_d;
    logic [5:0]   frame_end;
    logic [15:0]  rx_q,       rx_d;
    logic [15:0]  tx_q,       tx_d;
    logic [6:0]   addr_q,     addr_d;
    logic         wr_q,       wr_d;
    logic         dout_q,     dout_d;
    logic         oe_q,       oe_d;
    logic [7:0]   opm_q,      opm_d;
    logic [12:0]  apn_q,      apn_d;
    logic [11:0]  apd_q,      apd_d;
    logic [12:0]  vrn_q,      vrn_d;
    logic [11:0]  vrd_q,      vrd_d;
    logic [7:0]   ones_q,     ones_d;
    logic [2:0]   apr_q,      apr_d;
    logic [2:0]   vrr_q,      vrr_d;
    logic [31:0]  rst_cnt_q,  rst_cnt_d;
    logic         apo_q,      apo_d;
    logic         vro_q,      vro_d;
    logic [7:0]   dec_q,      dec_d;
    logic         busy_q,     busy_d;
    logic         sclk_fall;
    logic         sclk_rise;
    logic         active;
    logic         two_byte;
    logic [15:0]  rd_val;
    logic [7:0]   rd_ones;

    ////////////////////////////////////////////////////////////////////////////
    // Readback helpers

    // Register width decides frame length: one or two data bytes
    function automatic logic is_wide(input logic [6:0] a);
        is_wide = (a == CFS_ADDR_AP_NUM) || (a == CFS_ADDR_AP_DEN) ||
                  (a == CFS_ADDR_VAR_NUM) || (a == CFS_ADDR_VAR_DEN);
    endfunction : is_wide

    // Word for the address just shifted in; unmapped and reserved ones read zero
    always_comb
    begin
        unique case ({rx_q[5:0], din})
            CFS_ADDR_MODE:     rd_val = {8'h00, 1'b0, opm_q[6:0] & 7'h3f};
            CFS_ADDR_AP_NUM:   rd_val = {apr_q, apn_q};
            CFS_ADDR_AP_DEN:   rd_val = {4'h0, apd_q};
            CFS_ADDR_VAR_NUM:  rd_val = {vrr_q, vrn_q};
            CFS_ADDR_VAR_DEN:  rd_val = {4'h0, vrd_q};
            CFS_ADDR_ONES_CNT: rd_val = {8'h00, ones_q};
            CFS_ADDR_VERSION:  rd_val = {8'h00, DIE_VERSION};
            default:           rd_val = 16'h0000;
        endcase
    end

    // Ones in the word read; rx holds it through a read, so din never counts
    always_comb
    begin
        rd_ones = 8'h00;
        for (int i = 0; i < 16; i++)
        begin
            rd_ones = rd_ones + {7'h00, rx_q[i]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine and register file next state

    assign sclk_fall = sclk_q & ~sclk;
    assign sclk_rise = ~sclk_q & sclk;
    // Transfers during the soft-reset quiet time are dropped, not queued
    assign active    = ~cs_b & (rst_cnt_q == 32'h0);
    assign two_byte  = is_wide(addr_q);
    assign frame_end = two_byte ? 6'd24 : 6'd16;
    assign busy_d    = (rst_cnt_d != 32'h0);

    always_comb
    begin
        st_d      = st_q;
        sclk_d    = sclk;
        bit_cnt_d = bit_cnt_q;
        rx_d      = rx_q;
        tx_d      = tx_q;
        addr_d    = addr_q;
        wr_d      = wr_q;
        dout_d    = dout_q;
        oe_d      = oe_q;
        opm_d     = opm_q;
        apn_d     = apn_q;
        apd_d     = apd_q;
        vrn_d     = vrn_q;
        vrd_d     = vrd_q;
        ones_d    = ones_q;
        rst_cnt_d = (rst_cnt_q != 32'h0) ? rst_cnt_q - 32'h1 : 32'h0;
        // Polarity flags track the datapath every cycle
        apr_d     = {active_reverse[0], active_reverse[1], active_reverse[2]};
        vrr_d     = {reactive_reverse[0], reactive_reverse[1], reactive_reverse[2]};

        if (!active)
        begin
            st_d      = CFS_ST_CMD;
            bit_cnt_d = 6'd0;
            oe_d      = 1'b0;
        end
        else
        begin
            // Host drives data for the falling edge, device shifts out on rising
            if (sclk_fall && st_q != CFS_ST_DONE)
            begin
                rx_d      = (st_q == CFS_ST_DATA && !wr_q) ? rx_q : {rx_q[14:0], din};
                bit_cnt_d = bit_cnt_q + 6'd1;
                if (st_q == CFS_ST_CMD && bit_cnt_q == CFS_CMD_BITS - 6'd1)
                begin
                    wr_d   = rx_q[6];
                    addr_d = {rx_q[5:0], din};
                    tx_d   = is_wide({rx_q[5:0], din}) ? rd_val : {rd_val[7:0], 8'h00};
                    rx_d   = is_wide({rx_q[5:0], din}) ? rd_val : {8'h00, rd_val[7:0]};
                    st_d   = CFS_ST_DATA;
                end
                else if (st_q == CFS_ST_DATA && bit_cnt_q == frame_end - 6'd1)
                begin
                    st_d = CFS_ST_DONE;
                    if (wr_q)
                    begin
                        unique case (addr_q)
                            CFS_ADDR_MODE:
                            begin
                                opm_d = {rx_q[6:0], din};
                                opm_d[CFS_OPM_SRST_BIT] = 1'b0;
                                if (rx_q[CFS_OPM_SRST_BIT - 1])
                                begin
                                    // Soft reset returns every register to default
                                    opm_d     = CFS_MODE_RST;
                                    apn_d     = CFS_NUM_RST;
                                    apd_d     = CFS_DEN_RST;
                                    vrn_d     = CFS_NUM_RST;
                                    vrd_d     = CFS_DEN_RST;
                                    ones_d    = CFS_ONES_RST;
                                    rst_cnt_d = QUIET_CYCLES;
                                end
                            end
                            CFS_ADDR_AP_NUM:  apn_d = {rx_q[11:0], din};
                            CFS_ADDR_AP_DEN:  apd_d = {rx_q[10:0], din};
                            CFS_ADDR_VAR_NUM: vrn_d = {rx_q[11:0], din};
                            CFS_ADDR_VAR_DEN: vrd_d = {rx_q[10:0], din};
                            default:          opm_d = opm_q;
                        endcase
                    end
                    else if (addr_q != CFS_ADDR_ONES_CNT)
                    begin
                        ones_d = rd_ones;
                    end
                end
            end
            if (sclk_rise && st_q == CFS_ST_DATA && !wr_q)
            begin
                dout_d = tx_q[15];
                tx_d   = {tx_q[14:0], 1'b0};
                oe_d   = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and pulse gating next state

    always_comb
    begin
        dec_d = 8'h00;
        unique case (opm_q[CFS_OPM_SHUT_MSB:CFS_OPM_SHUT_LSB])
            CFS_SHUT_NORMAL:   dec_d = 8'h00;
            CFS_SHUT_SWAP:     dec_d[0] = 1'b1;
            CFS_SHUT_CUR_OFF:  dec_d[1] = 1'b1;
            CFS_SHUT_CUR_RTE:  dec_d[3:1] = 3'b101;                          // Off and redirected
            CFS_SHUT_VOLT_OFF: dec_d[2] = 1'b1;
            CFS_SHUT_VOLT_RTE: dec_d[4:2] = 3'b101;
            CFS_SHUT_SLEEP:    dec_d[5] = 1'b1;
            CFS_SHUT_PWRDN:    dec_d[6] = 1'b1;
        endcase
        // Both pulse outputs held low while disabled
        apo_d = active_pulse_raw & ~opm_q[CFS_OPM_CF_BIT];
        vro_d = reactive_pulse_raw & ~opm_q[CFS_OPM_CF_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q      <= CFS_ST_CMD;
            sclk_q    <= 1'b1;  // Idle level, so no false edge after reset
            bit_cnt_q <= 6'd0;
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
            addr_q    <= 7'h00;
            wr_q      <= 1'b0;
            dout_q    <= 1'b0;
            oe_q      <= 1'b0;
            opm_q     <= CFS_MODE_RST;
            apn_q     <= CFS_NUM_RST;
            apd_q     <= CFS_DEN_RST;
            vrn_q     <= CFS_NUM_RST;
            vrd_q     <= CFS_DEN_RST;
            ones_q    <= CFS_ONES_RST;
            apr_q     <= 3'h0;
            vrr_q     <= 3'h0;
            rst_cnt_q <= 32'h0;
            apo_q     <= 1'b0;
            vro_q     <= 1'b0;
            dec_q     <= 8'h00;
            busy_q    <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            sclk_q    <= sclk_d;
            bit_cnt_q <= bit_cnt_d;
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            addr_q    <= addr_d;
            wr_q      <= wr_d;
            dout_q    <= dout_d;
            oe_q      <= oe_d;
            opm_q     <= opm_d;
            apn_q     <= apn_d;
            apd_q     <= apd_d;
            vrn_q     <= vrn_d;
            vrd_q     <= vrd_d;
            ones_q    <= ones_d;
            apr_q     <= apr_d;
            vrr_q     <= vrr_d;
            rst_cnt_q <= rst_cnt_d;
            apo_q     <= apo_d;
            vro_q     <= vro_d;
            dec_q     <= dec_d;
            busy_q    <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops

    assign dout               = dout_q;
    assign dout_oe            = oe_q;
    assign active_scale_num   = apn_q;
    assign active_scale_den   = apd_q;
    assign reactive_scale_num = vrn_q;
    assign reactive_scale_den = vrd_q;
    assign active_pulse_out   = apo_q;
    assign reactive_pulse_out = vro_q;
    assign highpass_bypass    = opm_q[CFS_OPM_HPF_BIT];
    assign lowpass_bypass     = opm_q[CFS_OPM_LPF_BIT];
    assign pulse_outputs_off  = opm_q[CFS_OPM_CF_BIT];
    assign input_swap         = dec_q[0];
    assign current_adc_off    = dec_q[1];
    assign voltage_adc_off    = dec_q[2];
    assign current_to_voltage = dec_q[3];
    assign voltage_to_current = dec_q[4];
    assign sleep_mode         = dec_q[5];
    assign power_down         = dec_q[6];
    // Quiet time is visible so the system can hold off the host
    assign soft_reset_busy    = busy_q;

endmodule : cfs_regs

// ==== cfs_pkg.sv ====
// Package of offsets, fields, reset values and timing for the pulse-scaling register bank
package cfs_pkg;

    // Register addresses on the serial port
    localparam logic [6:0] CFS_ADDR_MODE      = 7'h13;
    localparam logic [6:0] CFS_ADDR_AP_NUM    = 7'h45;
    localparam logic [6:0] CFS_ADDR_AP_DEN    = 7'h46;
    localparam logic [6:0] CFS_ADDR_VAR_NUM   = 7'h47;
    localparam logic [6:0] CFS_ADDR_VAR_DEN   = 7'h48;
    localparam logic [6:0] CFS_ADDR_ONES_CNT  = 7'h7e;
    localparam logic [6:0] CFS_ADDR_VERSION   = 7'h7f;

    // Operating-mode field positions
    localparam int CFS_OPM_HPF_BIT   = 0;
    localparam int CFS_OPM_LPF_BIT   = 1;
    localparam int CFS_OPM_CF_BIT    = 2;
    localparam int CFS_OPM_SHUT_LSB  = 3;
    localparam int CFS_OPM_SHUT_MSB  = 5;
    localparam int CFS_OPM_SRST_BIT  = 6;

    // Numerator polarity flags sit above the scaling value
    localparam int CFS_NUM_VAL_W = 13;
    localparam int CFS_DEN_W     = 12;

    // Reset values
    localparam logic [7:0]  CFS_MODE_RST    = 8'h04;
    localparam logic [12:0] CFS_NUM_RST     = 13'h0000;
    localparam logic [11:0] CFS_DEN_RST     = 12'h03f;
    localparam logic [7:0]  CFS_ONES_RST    = 8'h00;

    // Converter shutdown codes
    localparam logic [2:0] CFS_SHUT_NORMAL   = 3'h0;
    localparam logic [2:0] CFS_SHUT_CUR_OFF  = 3'h1;
    localparam logic [2:0] CFS_SHUT_VOLT_OFF = 3'h2;
    localparam logic [2:0] CFS_SHUT_SLEEP    = 3'h3;
    localparam logic [2:0] CFS_SHUT_SWAP     = 3'h4;
    localparam logic [2:0] CFS_SHUT_CUR_RTE  = 3'h5;
    localparam logic [2:0] CFS_SHUT_VOLT_RTE = 3'h6;
    localparam logic [2:0] CFS_SHUT_PWRDN    = 3'h7;

    // Quiet time after a soft reset
    localparam int CFS_CLK_MHZ       = 250;
    localparam int CFS_QUIET_US      = 166;
    localparam int CFS_QUIET_CYCLES  = CFS_QUIET_US * CFS_CLK_MHZ;

    // Serial frame
    localparam logic [5:0] CFS_CMD_BITS = 6'd8;

endpackage : cfs_pkg

// ==== cfs_host_model.sv ====
// Host model: drives serial frames and returns the bits read back
`timescale 1ns/1ps
module cfs_host_model (
    input  wire logic        ref_clk,
    output logic             sclk,
    output logic             cs_b,
    output logic             din,
    input  wire logic        dout,
    output logic             rd_valid,
    output logic [15:0]      rd_data
);
    // Idle: clock parked high, chip deselected
    initial
    begin
        sclk = 1'b1;
        cs_b = 1'b1;
        din = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame; six-cycle clock phases leave room for the edge detector
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb);
        logic [23:0] sh;
        logic [15:0] rx;
        sh = {cmd, wd << (16 - nb)};
        rx = 16'h0000;
        cs_b = 1'b0;
        for (int i = 0; i < 8 + nb; i++)
        begin
            repeat (4) @(negedge ref_clk);
            if (i >= 8)
                rx = {rx[14:0], dout};
            // Data held low while reading so the ones count stays clean
            din = (i < 8 || cmd[7]) ? sh[23 - i] : 1'b0;
            repeat (2) @(negedge ref_clk);
            sclk = 1'b0;
            repeat (6) @(negedge ref_clk);
            sclk = 1'b1;
        end
        repeat (6) @(negedge ref_clk);
        cs_b = 1'b1;
        din = ~din;  // Released line never keeps its last value
        repeat (4) @(negedge ref_clk);
        if (!cmd[7])
        begin
            rd_data = rx;
            rd_valid = 1'b1;
            @(negedge ref_clk);
            rd_valid = 1'b0;
        end
    endtask : xfer
endmodule : cfs_host_model

// ==== cfs_regs_assertions.sv ====
// Checker for pulse gating, mode decode and soft reset timing
`timescale 1ns/1ps
module cfs_regs_chk #(
    parameter int QUIET_CYCLES = 20
)
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        cs_b,
    input wire logic        dout_oe,
    input wire logic        active_pulse_raw,
    input wire logic        active_pulse_out,
    input wire logic        reactive_pulse_raw,
    input wire logic        reactive_pulse_out,
    input wire logic [12:0] active_scale_num,
    input wire logic [11:0] active_scale_den,
    input wire logic [11:0] reactive_scale_den,
    input wire logic        pulse_outputs_off,
    input wire logic        input_swap,
    input wire logic        current_adc_off,
    input wire logic        voltage_adc_off,
    input wire logic        current_to_voltage,
    input wire logic        sleep_mode,
    input wire logic        power_down,
    input wire logic        soft_reset_busy
);
    int busy_cnt_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Busy length, restarted whenever the flag drops
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= soft_reset_busy ? busy_cnt_q + 1 : 0;

    ////////////////////////////////////////////////////////////////////////////
    chk_apulse_gate: assert property (active_pulse_out ==
        $past(active_pulse_raw & ~pulse_outputs_off)) else $error("active pulse not gated");
    chk_rpulse_gate: assert property (reactive_pulse_out ==
        $past(reactive_pulse_raw & ~pulse_outputs_off)) else $error("reactive pulse not gated");
    chk_swap_alone: assert property (input_swap |-> !current_adc_off &&
        !voltage_adc_off && !sleep_mode && !power_down) else $error("swap code mixed");
    chk_curoff_alone: assert property (current_adc_off |-> !voltage_adc_off &&
        !sleep_mode && !input_swap && !power_down) else $error("current off code mixed");
    chk_route_pair: assert property (current_to_voltage |-> current_adc_off
        && !power_down) else $error("redirect without converter off");
    chk_reset_defaults: assert property ($fell(soft_reset_busy) |->
        active_scale_den == 12'h03f && reactive_scale_den == 12'h03f && pulse_outputs_off)
        else $error("defaults not restored");
    chk_busy_len: assert property ($fell(soft_reset_busy) |->
        busy_cnt_q == QUIET_CYCLES) else $error("soft reset busy length");
    chk_num_quiet: assert property ($changed(active_scale_num) |-> !$past(cs_b))
        else $error("numerator changed outside a frame");
    chk_oe_release: assert property ($rose(cs_b) |-> ##[1:4] !dout_oe)
        else $error("output enable held after deselect");
endmodule : cfs_regs_chk

bind cfs_regs cfs_regs_chk #(.QUIET_CYCLES(QUIET_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .dout_oe(dout_oe),
    .active_pulse_raw(active_pulse_raw), .active_pulse_out(active_pulse_out),
    .reactive_pulse_raw(reactive_pulse_raw), .reactive_pulse_out(reactive_pulse_out),
    .active_scale_num(active_scale_num), .active_scale_den(active_scale_den),
    .reactive_scale_den(reactive_scale_den), .pulse_outputs_off(pulse_outputs_off),
    .input_swap(input_swap), .current_adc_off(current_adc_off),
    .voltage_adc_off(voltage_adc_off), .current_to_voltage(current_to_voltage),
    .sleep_mode(sleep_mode), .power_down(power_down), .soft_reset_busy(soft_reset_busy)
);

// ==== cfs_regs_tb.sv ====
// Testbench: host frames, register readback and mode decode checks
`timescale 1ns/1ps
module cfs_regs_tb;
    import cfs_pkg::*;
    localparam int         SWR   = 400;
    localparam logic [7:0] VER   = 8'h3c;  // Arbitrary value
    localparam int         LIMIT = 40000;
    logic ref_clk = 1'b0, rst_b = 1'b0;
    logic sclk, cs_b, din, dout, dout_oe, rd_valid;
    logic [15:0] rd_data, exp_v, e1, an, ad, vn, vd, m;
    logic [2:0] active_reverse = 3'h0, reactive_reverse = 3'h0;
    logic active_pulse_raw = 1'b1, reactive_pulse_raw = 1'b1;
    logic [12:0] active_scale_num, reactive_scale_num;
    logic [11:0] active_scale_den, reactive_scale_den;
    logic active_pulse_out, reactive_pulse_out, highpass_bypass, lowpass_bypass;
    logic pulse_outputs_off, input_swap, current_adc_off, voltage_adc_off, current_to_voltage;
    logic voltage_to_current, sleep_mode, power_down, soft_reset_busy;
    logic [15:0] exp_q[$];
    logic [6:0] dec [8] = '{7'h00, 7'h20, 7'h10, 7'h02, 7'h40, 7'h28, 7'h14, 7'h01};
    int n_errors = 0, check_count = 0, cyc = 0;
    int unsigned seed_v;
    logic oe_seen = 1'b0;

    always #2 ref_clk = ~ref_clk;

    cfs_regs #(.QUIET_CYCLES(SWR), .DIE_VERSION(VER)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout),
        .dout_oe(dout_oe), .active_reverse(active_reverse), .reactive_reverse(reactive_reverse),
        .active_pulse_raw(active_pulse_raw), .reactive_pulse_raw(reactive_pulse_raw),
        .active_scale_num(active_scale_num), .active_scale_den(active_scale_den),
        .reactive_scale_num(reactive_scale_num), .reactive_scale_den(reactive_scale_den),
        .active_pulse_out(active_pulse_out), .reactive_pulse_out(reactive_pulse_out),
        .highpass_bypass(highpass_bypass), .lowpass_bypass(lowpass_bypass),
        .pulse_outputs_off(pulse_outputs_off), .input_swap(input_swap),
        .current_adc_off(current_adc_off), .voltage_adc_off(voltage_adc_off),
        .current_to_voltage(current_to_voltage), .voltage_to_current(voltage_to_current),
        .sleep_mode(sleep_mode), .power_down(power_down), .soft_reset_busy(soft_reset_busy));

    cfs_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_b(cs_b), .din(din),
        .dout(dout), .rd_valid(rd_valid), .rd_data(rd_data));

    ////////////////////////////////////////////////////////////////////////////
    // Scaling registers take two data bytes, the rest one
    function automatic int nb(input logic [6:0] a);
        return (a >= CFS_ADDR_AP_NUM && a <= CFS_ADDR_VAR_DEN) ? 16 : 8;
    endfunction : nb

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer({1'b1, a}, d, nb(a));
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.xfer({1'b0, a}, 16'h0000, nb(a));
        // Enable must have risen for the read and dropped after deselect
        chk({oe_seen, dout_oe}, 16'h0002);
        oe_seen = 1'b0;
    endtask : rd

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task finish_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    // Each finished read meets the oldest note; an empty queue yields a mismatch
    always @(posedge rd_valid)
    begin
        exp_v = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
        chk(rd_data, exp_v);
    end

    // Notes that the data output was enabled during a read
    always @(posedge dout_oe) oe_seen = 1'b1;

    // Hang guard, well above the expected run length
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            finish_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed_v = $urandom(32'h1f568759);
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        chk({pulse_outputs_off, active_pulse_out}, 16'h0002);
        rd(CFS_ADDR_AP_DEN, 16'h003f);
        rd(CFS_ADDR_VAR_DEN, 16'h003f);
        rd(CFS_ADDR_MODE, 16'h0004);
        rd(7'h50, 16'h0000);
        rd(CFS_ADDR_VERSION, {8'h00, VER});
        rd(CFS_ADDR_ONES_CNT, 16'($countones(VER)));
        // Random scaling values, with live polarity on the top bits
        repeat (3)
        begin
            {an, ad} = $urandom;
            {vn, vd} = $urandom;
            wr(CFS_ADDR_AP_NUM, an);
            wr(CFS_ADDR_AP_DEN, ad);
            wr(CFS_ADDR_VAR_NUM, vn);
            wr(CFS_ADDR_VAR_DEN, vd);
            chk(active_scale_num, an[12:0]);
            chk(active_scale_den, ad[11:0]);
            chk(reactive_scale_num, vn[12:0]);
            chk(reactive_scale_den, vd[11:0]);
            active_reverse = 3'($urandom);
            reactive_reverse = 3'($urandom);
            e1 = {active_reverse[0], active_reverse[1], active_reverse[2], an[12:0]};
            rd(CFS_ADDR_AP_NUM, e1);
            rd(CFS_ADDR_ONES_CNT, 16'($countones(e1)));
            rd(CFS_ADDR_ONES_CNT, 16'($countones(e1)));
            rd(CFS_ADDR_VAR_NUM, {reactive_reverse[0], reactive_reverse[1],
                reactive_reverse[2], vn[12:0]});
            rd(CFS_ADDR_VAR_DEN, {4'h0, vd[11:0]});
        end
        // Every shutdown code with random filter and pulse bits
        for (int c = 0; c < 8; c++)
        begin
            m = {8'h00, 1'($urandom), 1'b0, 3'(c), 3'($urandom)};
            wr(CFS_ADDR_MODE, m);
            chk({pulse_outputs_off, lowpass_bypass, highpass_bypass}, m[2:0]);
            chk({active_pulse_out, reactive_pulse_out}, {2{~m[2]}});
            chk({input_swap, current_adc_off, voltage_adc_off, current_to_voltage,
                voltage_to_current, sleep_mode, power_down}, dec[c]);
            rd(CFS_ADDR_MODE, {10'h000, m[5:0]});
        end
        wr(CFS_ADDR_MODE, 16'h0000);
        repeat (30) @(negedge ref_clk) {active_pulse_raw, reactive_pulse_raw} = 2'($urandom);
        // Soft reset: a write inside the quiet time must be dropped
        wr(CFS_ADDR_MODE, 16'h0040);
        chk(soft_reset_busy, 16'h0001);
        wr(CFS_ADDR_AP_DEN, 16'h0123);
        repeat (SWR) @(negedge ref_clk);
        chk({soft_reset_busy, pulse_outputs_off}, 16'h0001);
        chk(active_scale_num, 16'h0000);
        rd(CFS_ADDR_AP_DEN, 16'h003f);
        rd(CFS_ADDR_MODE, 16'h0004);
        finish_test;
    end
endmodule : cfs_regs_tb
